// ---- design/cppm_consts.svh ----
// Constants for the charger power-path mode controller.
// Assumes inclusion by bare name from the design file.
`ifndef CPPM_CONSTS_SVH
`define CPPM_CONSTS_SVH
`define CPPM_ILIM_SUSPEND   2'h0
`define CPPM_ILIM_100MA     2'h1
`define CPPM_ILIM_500MA     2'h2
`define CPPM_ILIM_DEFAULT   2'h2
`define CPPM_SYNC_STAGES    2
`define CPPM_TEST_CYCLES    8'h10
`define CPPM_PRE_TIMER_DEF  24'h0F4240
`define CPPM_FAST_TIMER_DEF 24'hF42400
`endif

// ---- design/cppm_pkg.sv ----
// Types for the charger power-path mode controller.
// Assumes the constants header is on the include path.
package cppm_pkg;
   typedef enum logic [3:0] {
      CPPM_PDOWN   = 4'h0,
      CPPM_SLEEP   = 4'h1,
      CPPM_STANDBY = 4'h2,
      CPPM_POR_SET = 4'h3,
      CPPM_POR_SYS = 4'h4,
      CPPM_IDLE    = 4'h5,
      CPPM_BATTEST = 4'h6,
      CPPM_PRECHG  = 4'h7,
      CPPM_FASTCHG = 4'h8,
      CPPM_CV      = 4'h9,
      CPPM_DONE    = 4'hA
   } cppm_mode_e;

   // Analog comparator results, active high
   typedef struct packed {
      logic above_uvlo;
      logic above_bat_offset;
      logic overvoltage;
      logic set_pin_short;
      logic sys_above_sc;
      logic input_short_of_load;
      logic bat_above_short;
      logic bat_above_precharge_exit;
      logic bat_at_regulation;
      logic at_termination_current;
      logic loop_reduced;
      logic sum_over_input_limit;
   } cppm_comp_s;

   // Host control bits
   typedef struct packed {
      logic       system_switch_off;
      logic       charge_enable;
      logic [1:0] input_current_limit_select;
      logic [1:0] charge_scale;
      logic [1:0] precharge_select;
   } cppm_ctrl_s;
endpackage

// ---- design/cppm_mode_ctrl.sv ----
// Mode sequencer for a linear charger with power-path management.
// Assumes comparator inputs arrive asynchronously, host bits synchronous.
// Function
// - Below lockout stay powered down and ignore host commands.
// - Power-down: input switch off, battery switch on unless switch-off set.
// - Above lockout but below battery plus offset: sleep, ignore commands.
// - Above both thresholds: standby, power good set, commands accepted.
// - Suspend limit select or overvoltage forces standby.
// - Standby: input switch off, battery switch on unless switch-off set.
// - Overload monitor active in power-down, sleep and standby.
// - Enter power-on reset only with valid input and nonzero limit.
// - Power-on reset activates timers and charger blocks.
// - First check the set pin for a short; proceed only if clear.
// - Then turn on input switch with 100 mA limit to test load.
// - Load above short threshold: apply selected limit, enter idle.
// - Idle powers system from input and keeps monitoring.
// - Outside power-down, sleep and standby, battery switch on whenever input cannot carry the load.
// - Charge enable low with valid input returns to idle.
// - Load has priority; reduce charge current when input limit exceeded.
// - Programmed input limit defaults to 500 mA after reset.
// - Charging starts with a battery short test current.
// - Precharge, then fast charge, then hold regulation voltage.
// - Termination current reached releases status output.
// - Termination detection suppressed while a loop reduces charge rate.
// - Precharge level from select only, not scale, reduced under regulation.
// - Phase timer expiry sets the timer fault flag.
`timescale 1ns/10ps
`include "cppm_consts.svh"
module cppm_mode_ctrl #(
   parameter int          SYNC_STAGES = `CPPM_SYNC_STAGES,
   parameter logic [23:0] PRE_TIMER   = `CPPM_PRE_TIMER_DEF,
   parameter logic [23:0] FAST_TIMER  = `CPPM_FAST_TIMER_DEF
) (
   input  wire logic               clk_sys,
   input  wire logic               rst_b,
   input  wire cppm_pkg::cppm_comp_s comp_async,
   input  wire cppm_pkg::cppm_ctrl_s ctrl,
   input  wire logic               timer_fault_clear,
   output logic [3:0]              mode,
   output logic                    input_power_good,
   output logic                    commands_accepted,
   output logic                    input_switch,
   output logic                    battery_switch,
   output logic [1:0]              input_limit,
   output logic                    system_overload_monitor,
   output logic                    charger_active,
   output logic                    battery_test_current,
   output logic                    precharge_on,
   output logic                    fastcharge_on,
   output logic                    voltage_regulation,
   output logic                    charge_reduce,
   output logic [2:0]              precharge_level,
   output logic [1:0]              charge_scale_out,
   output logic                    charge_status_out,
   output logic                    charge_status_oe_b,
   output logic                    timer_fault
);
   import cppm_pkg::*;

   initial begin
      if (SYNC_STAGES < 2) begin
         $error("SYNC_STAGES must be at least 2");
      end
      if (PRE_TIMER == 24'h0 || FAST_TIMER == 24'h0) begin
         $error("Timers must be nonzero");
      end
   end

   localparam int CW = $bits(cppm_comp_s);

   // Plain shift chain; first stage read only by the next stage
   logic [CW-1:0] sync_q [SYNC_STAGES];
   cppm_comp_s    c;
   cppm_mode_e    mode_q;
   cppm_mode_e    mode_d;
   logic [23:0]   timer_q;
   logic [7:0]    test_q;
   logic          fault_set;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < SYNC_STAGES; i++) begin
            sync_q[i] <= '0;
         end
      end else begin
         sync_q[0] <= comp_async;
         for (int i = 1; i < SYNC_STAGES; i++) begin
            sync_q[i] <= sync_q[i-1];
         end
      end
   end
   assign c = cppm_comp_s'(sync_q[SYNC_STAGES-1]);

   function automatic logic input_valid(cppm_comp_s cc, logic [1:0] sel);
      input_valid = cc.above_uvlo && cc.above_bat_offset && !cc.overvoltage
                    && sel != `CPPM_ILIM_SUSPEND;
   endfunction

   function automatic logic is_off_mode(cppm_mode_e m);
      is_off_mode = (m == CPPM_PDOWN) || (m == CPPM_SLEEP)
                    || (m == CPPM_STANDBY);
   endfunction

   // Host bits only steer the sequence while commands are accepted
   logic cmd_ok;
   assign cmd_ok = !(mode_q == CPPM_PDOWN || mode_q == CPPM_SLEEP);

   always_comb begin
      mode_d = mode_q;
      if (!c.above_uvlo) begin
         mode_d = CPPM_PDOWN;
      end else if (!c.above_bat_offset) begin
         mode_d = CPPM_SLEEP;
      end else if (c.overvoltage
                   || ctrl.input_current_limit_select == `CPPM_ILIM_SUSPEND)
      begin
         mode_d = CPPM_STANDBY;
      end else begin
         unique case (mode_q)
            CPPM_PDOWN, CPPM_SLEEP: begin
               mode_d = CPPM_STANDBY;
            end
            CPPM_STANDBY: begin
               if (input_valid(c, ctrl.input_current_limit_select)) begin
                  mode_d = CPPM_POR_SET;
               end
            end
            CPPM_POR_SET: begin
               if (!c.set_pin_short) begin
                  mode_d = CPPM_POR_SYS;
               end
            end
            CPPM_POR_SYS: begin
               if (c.sys_above_sc) begin
                  mode_d = CPPM_IDLE;
               end
            end
            CPPM_IDLE: begin
               if (ctrl.charge_enable) begin
                  mode_d = CPPM_BATTEST;
               end
            end
            CPPM_BATTEST: begin
               if (c.bat_above_short) begin
                  mode_d = CPPM_PRECHG;
               end
            end
            CPPM_PRECHG: begin
               if (c.bat_above_precharge_exit) begin
                  mode_d = CPPM_FASTCHG;
               end
            end
            CPPM_FASTCHG: begin
               if (c.bat_at_regulation) begin
                  mode_d = CPPM_CV;
               end
            end
            CPPM_CV: begin
               if (c.at_termination_current && !c.loop_reduced) begin
                  mode_d = CPPM_DONE;
               end
            end
            CPPM_DONE: begin
               mode_d = CPPM_DONE;
            end
            default: begin
               mode_d = CPPM_PDOWN;
            end
         endcase
         if (!ctrl.charge_enable && mode_q inside {CPPM_BATTEST, CPPM_PRECHG,
             CPPM_FASTCHG, CPPM_CV, CPPM_DONE}) begin
            mode_d = CPPM_IDLE;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mode_q <= CPPM_PDOWN;
      end else begin
         mode_q <= mode_d;
      end
   end

   // Phase safety timer, restarted on each phase change
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         timer_q <= 24'h0;
      end else if (mode_d != mode_q) begin
         timer_q <= 24'h0;
      end else if ((mode_q == CPPM_PRECHG && timer_q != PRE_TIMER)
                || (mode_q inside {CPPM_FASTCHG, CPPM_CV}
                    && timer_q != FAST_TIMER)) begin
         timer_q <= timer_q + 24'h1;
      end
   end

   assign fault_set = (mode_q == CPPM_PRECHG && timer_q == PRE_TIMER)
                   || (mode_q inside {CPPM_FASTCHG, CPPM_CV}
                       && timer_q == FAST_TIMER);

   // Set wins over a simultaneous clear
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         timer_fault <= 1'b0;
      end else if (fault_set) begin
         timer_fault <= 1'b1;
      end else if (timer_fault_clear && cmd_ok) begin
         timer_fault <= 1'b0;
      end
   end

   // Battery short test strobe counter
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         test_q <= 8'h0;
      end else if (mode_q == CPPM_BATTEST && test_q != `CPPM_TEST_CYCLES) begin
         test_q <= test_q + 8'h1;
      end else if (mode_q != CPPM_BATTEST) begin
         test_q <= 8'h0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mode                    <= 4'h0;
         input_power_good        <= 1'b0;
         commands_accepted       <= 1'b0;
         input_switch            <= 1'b0;
         battery_switch          <= 1'b1;
         input_limit             <= `CPPM_ILIM_DEFAULT;
         system_overload_monitor <= 1'b1;
         charger_active          <= 1'b0;
         charge_scale_out        <= 2'h0;
      end else begin
         mode              <= mode_d;
         input_power_good  <= !is_off_mode(mode_d)
                              || mode_d == CPPM_STANDBY;
         commands_accepted <= !(mode_d == CPPM_PDOWN
                                || mode_d == CPPM_SLEEP);
         input_switch      <= !is_off_mode(mode_d)
                              && mode_d != CPPM_POR_SET;
         if (is_off_mode(mode_d)) begin
            battery_switch <= !ctrl.system_switch_off;
         end else begin
            battery_switch <= c.input_short_of_load;
         end
         if (mode_d == CPPM_POR_SYS) begin
            input_limit <= `CPPM_ILIM_100MA;
         end else if (!is_off_mode(mode_d) && mode_d != CPPM_POR_SET) begin
            input_limit <= ctrl.input_current_limit_select;
         end
         system_overload_monitor <= is_off_mode(mode_d);
         charger_active    <= !is_off_mode(mode_d);
         charge_scale_out  <= ctrl.charge_scale;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         battery_test_current <= 1'b0;
         precharge_on         <= 1'b0;
         fastcharge_on        <= 1'b0;
         voltage_regulation   <= 1'b0;
         charge_reduce        <= 1'b0;
         precharge_level      <= 3'h0;
         charge_status_out    <= 1'b0;
         charge_status_oe_b   <= 1'b1;
      end else begin
         battery_test_current <= mode_d == CPPM_BATTEST;
         precharge_on         <= mode_d == CPPM_PRECHG;
         fastcharge_on        <= mode_d inside {CPPM_FASTCHG, CPPM_CV};
         voltage_regulation   <= mode_d == CPPM_CV;
         charge_reduce        <= c.sum_over_input_limit;
         // One step lower while any regulation loop is active
         precharge_level      <= {1'b0, ctrl.precharge_select}
                                 + {2'b0, ~c.loop_reduced};
         charge_status_out    <= 1'b0;
         // Open drain: driven low while charging, released when done
         charge_status_oe_b   <= !(mode_d inside {CPPM_BATTEST, CPPM_PRECHG,
                                 CPPM_FASTCHG, CPPM_CV});
      end
   end

   pdown_switch_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (mode == 4'h0) |-> (!input_switch && system_overload_monitor))
      else $error("Input switch on in power-down");
   sleep_cmd_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (mode == 4'h1) |-> !commands_accepted)
      else $error("Commands accepted in sleep");
   standby_good_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (mode == 4'h2) |-> (input_power_good && !input_switch))
      else $error("Standby outputs wrong");
   system_switch_off_bat_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (mode inside {4'h0, 4'h1, 4'h2}) |-> battery_switch
      == !$past(ctrl.system_switch_off))
      else $error("Battery switch ignores switch-off");
   syscheck_lim_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (mode == 4'h4) |-> (input_limit == 2'h1 && input_switch))
      else $error("Load test not at 100 mA");
   setpin_wait_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (mode == 4'h3 && c.set_pin_short && c.above_uvlo
       && c.above_bat_offset && !c.overvoltage
       && ctrl.input_current_limit_select != 2'h0) |=> (mode == 4'h3))
      else $error("Left set-pin check with short");
   done_release_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (mode == 4'hA) |-> charge_status_oe_b)
      else $error("Status not released when done");
   fault_sticky_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      fault_set |=> timer_fault)
      else $error("Timer fault not set");
endmodule

// ---- testbench/cppm_host_model.sv ----
// Far-side model: analog comparator levels and host control bits.
// Assumes the bench updates requests by non-blocking assignment.
`timescale 1ns/10ps
module cppm_host_model (
   input  wire logic                 clk_sys,
   input  wire cppm_pkg::cppm_comp_s comp_req,
   input  wire cppm_pkg::cppm_ctrl_s ctrl_req,
   output cppm_pkg::cppm_comp_s      comp_async,
   output cppm_pkg::cppm_ctrl_s      ctrl
);
   import cppm_pkg::*;

   // Known levels from time zero, no unknowns into the synchronisers
   initial begin
      comp_async = '0;
      ctrl       = '0;
   end

   // Falling edge keeps changes well clear of the sampling edge
   always @(negedge clk_sys) begin
      comp_async <= comp_req;
      ctrl       <= ctrl_req;
   end
endmodule

// ---- testbench/cppm_mode_ctrl_test.sv ----
// Self-checking bench for the charger power-path mode controller.
// Assumes the design package and short phase timers for simulation.
`timescale 1ns/10ps
module cppm_mode_ctrl_test;
   import cppm_pkg::*;

   typedef struct {
      logic [11:0] comp;
      logic [7:0]  ctl;
      logic [3:0]  mode;
      logic [5:0]  flags;
      logic [5:0]  mask;
   } cppm_row_s;

   logic        clk_sys;
   logic        rst_b;
   logic        timer_fault_clear;
   cppm_comp_s  comp_req;
   cppm_ctrl_s  ctrl_req;
   cppm_comp_s  comp_async;
   cppm_ctrl_s  ctrl;
   logic [3:0]  mode;
   logic        input_power_good;
   logic        commands_accepted;
   logic        input_switch;
   logic        battery_switch;
   logic [1:0]  input_limit;
   logic        system_overload_monitor;
   logic        charger_active;
   logic        battery_test_current;
   logic        fastcharge_on;
   logic        voltage_regulation;
   logic        charge_status_out;
   logic        precharge_on;
   logic        charge_reduce;
   logic [2:0]  precharge_level;
   logic [1:0]  charge_scale_out;
   logic        charge_status_oe_b;
   logic        timer_fault;
   logic [5:0]  flags;
   int          num_errors;
   int          tests_run;
   cppm_row_s   rows [14];

   assign flags = {input_power_good, commands_accepted, input_switch,
                   battery_switch, system_overload_monitor,
                   charge_status_oe_b};

   cppm_host_model cppm_host_model_inst (
      .clk_sys    (clk_sys),
      .comp_req   (comp_req),
      .ctrl_req   (ctrl_req),
      .comp_async (comp_async),
      .ctrl       (ctrl)
   );

   // Short timers keep the fault scenario brief
   cppm_mode_ctrl #(
      .PRE_TIMER  (24'h000014),
      .FAST_TIMER (24'h000028)
   ) cppm_mode_ctrl_inst (
      .clk_sys                 (clk_sys),
      .rst_b                   (rst_b),
      .comp_async              (comp_async),
      .ctrl                    (ctrl),
      .timer_fault_clear       (timer_fault_clear),
      .mode                    (mode),
      .input_power_good        (input_power_good),
      .commands_accepted       (commands_accepted),
      .input_switch            (input_switch),
      .battery_switch          (battery_switch),
      .input_limit             (input_limit),
      .system_overload_monitor (system_overload_monitor),
      .charger_active          (charger_active),
      .battery_test_current    (battery_test_current),
      .precharge_on            (precharge_on),
      .fastcharge_on           (fastcharge_on),
      .voltage_regulation      (voltage_regulation),
      .charge_reduce           (charge_reduce),
      .precharge_level         (precharge_level),
      .charge_scale_out        (charge_scale_out),
      .charge_status_out       (charge_status_out),
      .charge_status_oe_b      (charge_status_oe_b),
      .timer_fault             (timer_fault)
   );

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk_mode(input logic [3:0] exp);
      tests_run++;
      if (mode !== exp) begin
         num_errors++;
         $display("wrong value at %0t: mode %h not %h", $time, mode, exp);
      end
   endtask

   task automatic chk_bits(input logic [5:0] got, input logic [5:0] exp,
                           input logic [5:0] msk, input string what);
      tests_run++;
      if ((got & msk) !== (exp & msk)) begin
         num_errors++;
         $display("wrong value at %0t: %s got %b", $time, what, got);
      end
   endtask

   // Bounded wait; a stuck mode ends the run
   task automatic wait_mode(input logic [3:0] exp);
      int n;
      n = 0;
      while (mode !== exp && n < 30) begin
         @(negedge clk_sys);
         n++;
      end
      if (mode !== exp) begin
         num_errors++;
         $display("wrong value at %0t: mode stuck at %h", $time, mode);
         final_report();
      end
   endtask

   task automatic drive(input logic [11:0] c, input logic [7:0] k);
      @(negedge clk_sys);
      comp_req <= c;
      ctrl_req <= k;
   endtask

   task automatic chk_reset();
      chk_mode(4'h0);
      chk_bits({timer_fault, input_limit, battery_switch,
                system_overload_monitor, charge_status_oe_b},
               6'h17, 6'h3F, "reset");
   endtask

   initial begin
      num_errors = 0;
      tests_run = 0;
      rst_b = 1'b0;
      timer_fault_clear = 1'b0;
      comp_req = '0;
      ctrl_req = '0;
      // Flags: good, accepted, input sw, battery sw, monitor, status oe_b
      rows[0]  = '{12'h000, 8'h60, 4'h0, 6'h07, 6'h3F};
      rows[1]  = '{12'h800, 8'h60, 4'h1, 6'h07, 6'h3F};
      rows[2]  = '{12'hC00, 8'h40, 4'h2, 6'h37, 6'h3F};
      rows[3]  = '{12'hC00, 8'hC0, 4'h2, 6'h33, 6'h3F};
      rows[4]  = '{12'hC80, 8'h20, 4'h5, 6'h09, 6'h0D};
      rows[5]  = '{12'hCC0, 8'h20, 4'h5, 6'h0D, 6'h0D};
      rows[6]  = '{12'hC80, 8'h60, 4'h6, 6'h00, 6'h01};
      rows[7]  = '{12'hCA0, 8'h60, 4'h7, 6'h00, 6'h01};
      rows[8]  = '{12'hCB0, 8'h60, 4'h8, 6'h00, 6'h01};
      rows[9]  = '{12'hCB8, 8'h60, 4'h9, 6'h00, 6'h01};
      rows[10] = '{12'hCBE, 8'h60, 4'h9, 6'h00, 6'h01};
      rows[11] = '{12'hCBC, 8'h60, 4'hA, 6'h01, 6'h01};
      rows[12] = '{12'hCBC, 8'h20, 4'h5, 6'h08, 6'h08};
      rows[13] = '{12'hEBC, 8'h20, 4'h2, 6'h04, 6'h0C};
      repeat (16) @(negedge clk_sys);
      chk_reset();
      rst_b = 1'b1;
      $display("reset test done");
      foreach (rows[i]) begin
         drive(rows[i].comp, rows[i].ctl);
         wait_mode(rows[i].mode);
         // Settle time also shows a mode that would move on wrongly
         repeat (6) @(negedge clk_sys);
         chk_mode(rows[i].mode);
         chk_bits(flags, rows[i].flags, rows[i].mask, "flags");
         chk_bits({1'b0, charge_status_out, battery_test_current,
                   precharge_on, fastcharge_on, voltage_regulation},
                  {2'b00, rows[i].mode == 4'h6, rows[i].mode == 4'h7,
                   rows[i].mode inside {4'h8, 4'h9}, rows[i].mode == 4'h9},
                  6'h1F, "phase");
         $display("row %0d done", i);
      end
      // Set-pin short holds the start-up check
      drive(12'hD00, 8'h20);
      wait_mode(4'h3);
      repeat (8) @(negedge clk_sys);
      chk_mode(4'h3);
      chk_bits({input_switch, charger_active, 4'h0},
               6'h10, 6'h30, "set pin check");
      drive(12'hC00, 8'h20);
      wait_mode(4'h4);
      repeat (4) @(negedge clk_sys);
      chk_bits({input_switch, 3'h0, input_limit},
               6'h21, 6'h23, "load check");
      drive(12'hC80, 8'h20);
      wait_mode(4'h5);
      @(negedge clk_sys);
      chk_bits({4'h0, input_limit}, 6'h02, 6'h03, "limit");
      $display("start-up test done");
      // Precharge level, load priority and phase timer
      drive(12'hCA0, 8'h6E);
      wait_mode(4'h7);
      @(negedge clk_sys);
      chk_bits({precharge_on, precharge_level, charge_scale_out},
               6'h2F, 6'h3F, "precharge");
      chk_bits({5'h0, timer_fault}, 6'h00, 6'h01, "early fault");
      drive(12'hCA2, 8'h6E);
      repeat (5) @(negedge clk_sys);
      chk_bits({1'b0, precharge_level, 2'h0},
               6'h08, 6'h1C, "reduced level");
      drive(12'hCA3, 8'h6E);
      repeat (5) @(negedge clk_sys);
      chk_bits({5'h0, charge_reduce}, 6'h01, 6'h01, "reduce");
      repeat (20) @(negedge clk_sys);
      chk_bits({5'h0, timer_fault}, 6'h01, 6'h01, "timer fault");
      // Clear while expiry still stands: set wins
      timer_fault_clear = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk_bits({5'h0, timer_fault}, 6'h01, 6'h01, "set wins");
      drive(12'hCB0, 8'h6E);
      wait_mode(4'h8);
      repeat (2) @(negedge clk_sys);
      chk_bits({5'h0, timer_fault}, 6'h00, 6'h01, "fault clear");
      timer_fault_clear = 1'b0;
      $display("charge test done");
      // Reset in mid-run returns to the powered-down defaults
      rst_b = 1'b0;
      @(negedge clk_sys);
      chk_reset();
      rst_b = 1'b1;
      $display("mid-run reset test done");
      final_report();
   end
endmodule
